// ### dcct_fifo.sv
`timescale 1ns/1ps
module dcct_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic  clock,
  input  wire logic  rst_n,
  input  wire logic  ce,
  dcct_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [AW:0]      next_count;
  logic             doWr;
  logic             doRd;

  // Honest flags; a write into a full buffer is never taken
  assign port.wrReady = (count != (AW+1)'(DEPTH));
  assign port.rdValid = (count != '0);
  assign port.rdData  = mem[rdPtr];
  assign port.level   = count;

  ////////////////////////////////////////////////////////////////////
  // Pointer and fill arithmetic
  always_comb
  begin
    doWr       = ce & port.wrValid & port.wrReady;
    doRd       = ce & port.rdValid & port.rdReady;
    next_wrPtr = doWr ? AW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = doRd ? AW'(rdPtr + 1'b1) : rdPtr;
    next_count = count;
    if (doWr && !doRd)
      next_count = (AW+1)'(count + 1'b1);
    else if (doRd && !doWr)
      next_count = (AW+1)'(count - 1'b1);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage has no reset; only the count entries from rdPtr onward are ever read
  always_ff @(posedge clock)
  begin
    if (doWr)
      mem[wrPtr] <= port.wrData;
  end

  ////////////////////////////////////////////////////////////////////
  a_fifo_bound: assert property (@(posedge clock) disable iff (!rst_n)
    count <= (AW+1)'(DEPTH))
    else $error("Buffer fill above depth");

  a_fifo_full_stall: assert property (@(posedge clock) disable iff (!rst_n)
    (count == (AW+1)'(DEPTH)) && !doRd |=> count == $past(count))
    else $error("Full buffer took a write");
endmodule

// ### dcct_fifo_if.sv
`timescale 1ns/1ps
interface dcct_fifo_if #(parameter int WIDTH = 8, parameter int DEPTH = 32);
  logic                   wrValid;
  logic                   wrReady;
  logic [WIDTH-1:0]       wrData;
  logic                   rdValid;
  logic                   rdReady;
  logic [WIDTH-1:0]       rdData;
  logic [$clog2(DEPTH):0] level;

  // Buffer side
  modport store (input wrValid, wrData, rdReady,
                 output wrReady, rdValid, rdData, level);
  // Channel side
  modport user (output wrValid, wrData, rdReady,
                input wrReady, rdValid, rdData, level);
endinterface

// ### dcct_partner.sv
`timescale 1ns/1ps
module dcct_partner (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        srcOn,
  input  wire logic [31:0] allow,
  output      logic        inByteValid,
  output      logic [7:0]  inByteData,
  input  wire logic        inByteReady,
  input  wire logic        outByteValid,
  output      logic        outByteReady
);
  int         taken;
  logic [7:0] cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Source offers a rolling byte; idle data is scrambled so nothing leans on it
  assign inByteValid  = srcOn;
  assign inByteData   = srcOn ? cnt : ~cnt;
  // Sink stalls once its byte budget is spent
  assign outByteReady = taken < allow;

  ////////////////////////////////////////////////////////////////////////////
  // Byte and budget bookkeeping
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      taken <= 0;
      cnt   <= 8'h00;
    end
    else
    begin
      if (inByteValid && inByteReady)
        cnt <= cnt + 8'h01;
      if (outByteValid && outByteReady)
        taken <= taken + 1;
    end
endmodule

// ### dcct_pkg.sv
package dcct_pkg;
  // Data path and buffer shape
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int WB_ADR_W   = 5;

  // Register byte offsets
  localparam logic [4:0] OFS_SIZE = 5'h00;
  localparam logic [4:0] OFS_PTR  = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0c;

  // Reset values
  localparam logic [15:0] SIZE_RESET = 16'h0000;
  localparam logic [15:0] PTR_RESET  = 16'h0000;
  localparam logic        CTRL_RESET = 1'b0;

  // Field positions
  localparam int FIELD_MSB    = 15;
  localparam int CTRL_PAT_BIT = 0;
  localparam int STAT_MOV_BIT = 0;
  localparam int STAT_LVL_LSB = 8;

  // Channel sequencing
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_MOVE = 2'b10
  } dcct_state_type;
endpackage

// ### dcct_top.sv
`timescale 1ns/1ps
module dcct_top (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [dcct_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output      logic [31:0]                   wb_dat_o,
  output      logic                          wb_ack_o,
  input  wire logic                          inByteValid,
  input  wire logic [dcct_pkg::DATA_W-1:0]   inByteData,
  output      logic                          inByteReady,
  input  wire logic                          cellStart,
  input  wire logic                          patternMatch,
  output      logic                          outByteValid,
  output      logic [dcct_pkg::DATA_W-1:0]   outByteData,
  input  wire logic                          outByteReady,
  output      logic                          cellDone
);
  dcct_pkg::dcct_state_type state;
  dcct_pkg::dcct_state_type next_state;
  logic [15:0]              cellByteCount;
  logic [15:0]              next_cellByteCount;
  logic [15:0]              cellProgressPointer;
  logic [15:0]              next_cellProgressPointer;
  logic                     patternMode;
  logic                     next_patternMode;
  logic [31:0]              next_wb_dat_o;
  logic                     next_wb_ack_o;
  logic                     wbReq;
  logic [4:0]               wordAdr;
  logic                     moving;
  logic                     moveByte;
  logic                     lastByte;
  logic                     patClear;
  logic [15:0]              ptrPlusOne;
  logic [15:0]              wrLow;

  dcct_fifo_if #(.WIDTH(dcct_pkg::DATA_W), .DEPTH(dcct_pkg::FIFO_DEPTH))
    fifoBus ();

  dcct_fifo #(.WIDTH(dcct_pkg::DATA_W), .DEPTH(dcct_pkg::FIFO_DEPTH))
    u_fifo (
      .clock (clock),
      .rst_n (rst_n),
      .ce    (ce),
      .port  (fifoBus.store)
    );

  ////////////////////////////////////////////////////////////////////
  // Byte path: source fills the buffer, the channel drains it
  assign fifoBus.wrValid = inByteValid & ce;
  assign fifoBus.wrData  = inByteData;
  assign inByteReady     = fifoBus.wrReady & ce; // Full buffer stalls source
  assign moving          = (state == dcct_pkg::ST_MOVE);
  assign fifoBus.rdReady = moving & outByteReady;
  assign outByteValid    = ce & moving & fifoBus.rdValid;
  assign outByteData     = fifoBus.rdData;

  // Cell bookkeeping terms
  assign moveByte   = outByteValid & outByteReady;
  assign ptrPlusOne = cellProgressPointer + 16'h0001;
  // Compare on >= so a smaller size written mid-cell still ends it
  assign lastByte   = (ptrPlusOne >= cellByteCount);
  assign patClear   = ce & patternMode & patternMatch;
  assign cellDone   = moveByte & lastByte & ~patClear;

  ////////////////////////////////////////////////////////////////////
  // Channel sequencing and cell pointer
  always_comb
  begin
    next_state               = state;
    next_cellProgressPointer = cellProgressPointer;
    case (state)
      dcct_pkg::ST_IDLE:
      begin
        // A zero cell size moves nothing, so the event is dropped
        if (ce && cellStart && !patClear && cellByteCount != 16'h0000)
          next_state = dcct_pkg::ST_MOVE;
      end
      dcct_pkg::ST_MOVE:
      begin
        if (patClear || cellDone)
          next_state = dcct_pkg::ST_IDLE;
      end
      default:
        next_state = dcct_pkg::ST_IDLE;
    endcase
    if (patClear)
      next_cellProgressPointer = dcct_pkg::PTR_RESET;
    else if (moveByte)
    begin
      if (lastByte)
        next_cellProgressPointer = dcct_pkg::PTR_RESET;
      else
        next_cellProgressPointer = ptrPlusOne;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state               <= dcct_pkg::ST_IDLE;
      cellProgressPointer <= dcct_pkg::PTR_RESET;
    end
    else if (ce)
    begin
      state               <= next_state;
      cellProgressPointer <= next_cellProgressPointer;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, dropped after one
  assign wbReq   = ce & wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wordAdr = {wb_adr_i[4:2], 2'b00};
  assign wrLow   = wb_dat_i[15:0];

  always_comb
  begin
    next_cellByteCount = cellByteCount;
    next_patternMode   = patternMode;
    next_wb_ack_o      = wbReq;
    next_wb_dat_o      = wb_dat_o;
    if (wbReq && wb_we_i)
    begin
      // Upper half has no storage; pointer writes fall through
      case (wordAdr)
        dcct_pkg::OFS_SIZE:
        begin
          if (wb_sel_i[0])
            next_cellByteCount[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1])
            next_cellByteCount[15:8] = wb_dat_i[15:8];
        end
        dcct_pkg::OFS_CTRL:
        begin
          if (wb_sel_i[0])
            next_patternMode = wb_dat_i[dcct_pkg::CTRL_PAT_BIT];
        end
        default:
          next_patternMode = patternMode;
      endcase
    end
    if (wbReq && !wb_we_i)
    begin
      next_wb_dat_o = 32'h0000_0000;
      case (wordAdr)
        dcct_pkg::OFS_SIZE:
          next_wb_dat_o[dcct_pkg::FIELD_MSB:0] = cellByteCount;
        dcct_pkg::OFS_PTR:
          next_wb_dat_o[dcct_pkg::FIELD_MSB:0] = cellProgressPointer;
        dcct_pkg::OFS_CTRL:
          next_wb_dat_o[dcct_pkg::CTRL_PAT_BIT] = patternMode;
        dcct_pkg::OFS_STAT:
        begin
          next_wb_dat_o[dcct_pkg::STAT_MOV_BIT] = moving;
          next_wb_dat_o[dcct_pkg::STAT_LVL_LSB +: 6] = fifoBus.level;
        end
        default:
          next_wb_dat_o = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cellByteCount <= dcct_pkg::SIZE_RESET;
      patternMode   <= dcct_pkg::CTRL_RESET;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
    end
    else if (ce)
    begin
      cellByteCount <= next_cellByteCount;
      patternMode   <= next_patternMode;
      wb_ack_o      <= next_wb_ack_o;
      wb_dat_o      <= next_wb_dat_o;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_wb_req;
    wbReq;
  endsequence

  sequence s_size_write;
    wbReq && wb_we_i && wordAdr == dcct_pkg::OFS_SIZE && wb_sel_i[1:0] == 2'b11;
  endsequence

  sequence s_ptr_read;
    wbReq && !wb_we_i &&
      (wordAdr == dcct_pkg::OFS_PTR || wordAdr == dcct_pkg::OFS_SIZE);
  endsequence

  a_bus_ack_once: assert property (
    s_wb_req |=> wb_ack_o ##1 (!wb_ack_o || !ce))
    else $error("Ack not a single cycle after request");

  a_size_write: assert property (
    s_size_write |=> cellByteCount == $past(wrLow))
    else $error("Cell size write not stored");

  a_upper_zero: assert property (
    s_ptr_read |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000)
    else $error("Upper half of register read nonzero");

  a_ptr_readonly: assert property (
    wbReq && wb_we_i && wordAdr == dcct_pkg::OFS_PTR && !moveByte && !patClear
    |=> $stable(cellProgressPointer))
    else $error("Cell pointer changed by a write");

  a_pattern_clear: assert property (
    patClear |=> cellProgressPointer == 16'h0000 && state == dcct_pkg::ST_IDLE)
    else $error("Pattern match did not clear pointer");

  a_ptr_step: assert property (
    moveByte && !lastByte && !patClear
    |=> cellProgressPointer == $past(ptrPlusOne))
    else $error("Pointer did not advance by one");

  a_cell_end: assert property (
    cellDone |-> cellProgressPointer == 16'(cellByteCount - 16'h0001)
    ##1 cellProgressPointer == 16'h0000 && !moving)
    else $error("Cell did not end at cell size");

  a_idle_no_move: assert property (
    !moving |-> !outByteValid && !cellDone)
    else $error("Byte moved outside a cell");

  // Read data must show the register as it stood when the request was taken
  sequence s_size_read;
    wbReq && !wb_we_i && wordAdr == dcct_pkg::OFS_SIZE;
  endsequence

  sequence s_ptr_only_read;
    wbReq && !wb_we_i && wordAdr == dcct_pkg::OFS_PTR;
  endsequence

  sequence s_cell_open;
    ce && cellStart && !moving && !patClear && cellByteCount != 16'h0000;
  endsequence

  sequence s_ctrl_write;
    wbReq && wb_we_i && wordAdr == dcct_pkg::OFS_CTRL && wb_sel_i[0];
  endsequence

  a_size_readback: assert property (
    s_size_read |=> wb_dat_o[15:0] == $past(cellByteCount))
    else $error("Cell size read back wrong");

  a_ptr_readback: assert property (
    s_ptr_only_read |=> wb_dat_o[15:0] == $past(cellProgressPointer))
    else $error("Cell pointer read back wrong");

  // Size moves only on a size write; upper data bits never reach it
  a_size_hold: assert property (
    !(wbReq && wb_we_i && wordAdr == dcct_pkg::OFS_SIZE)
    |=> $stable(cellByteCount))
    else $error("Cell size changed without a write");

  // Only a moved byte or a pattern match may touch the pointer
  a_ptr_hold: assert property (
    !moveByte && !patClear |=> $stable(cellProgressPointer))
    else $error("Cell pointer changed on its own");

  a_ptr_idle_zero: assert property (
    !moving |-> cellProgressPointer == 16'h0000)
    else $error("Cell pointer nonzero between cells");

  a_cell_open: assert property (
    s_cell_open |=> moving && cellProgressPointer == 16'h0000)
    else $error("Start event did not open a cell");

  a_zero_size_drop: assert property (
    !moving && cellByteCount == 16'h0000 |=> !moving)
    else $error("Zero cell size opened a cell");

  a_done_single: assert property (
    cellDone |=> !moving && !cellDone)
    else $error("Cell end not followed by idle");

  a_ctrl_write: assert property (
    s_ctrl_write |=> patternMode == $past(wb_dat_i[dcct_pkg::CTRL_PAT_BIT]))
    else $error("Pattern mode write not stored");

  // A match outside pattern mode must leave the cell running untouched
  a_match_ignored: assert property (
    !patternMode && patternMatch && moving && !moveByte
    |=> moving && $stable(cellProgressPointer))
    else $error("Match acted outside pattern mode");

  a_ack_no_req: assert property (
    ce && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("Ack without a request");
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clock        = 1'b0;
  logic        rst_n        = 1'b0;
  logic        wbCyc        = 1'b0;
  logic        wbStb        = 1'b0;
  logic        wbWe         = 1'b0;
  logic [4:0]  wbAdr        = 5'h00;
  logic [3:0]  wbSel        = 4'h0;
  logic [31:0] wbDatI       = 32'h0;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic        cellStart    = 1'b0;
  logic        patternMatch = 1'b0;
  logic        srcOn        = 1'b0;
  int          allow        = 0;
  logic        inByteValid, inByteReady, outByteValid, outByteReady;
  logic        cellDone;
  logic [7:0]  inByteData, outByteData;
  logic [7:0]  expByte      = 8'h00;
  int          moved        = 0;
  int          dones        = 0;
  int          errTotal     = 0;
  int          numChecks    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances; ce stays high so nothing is frozen
  always #10 clock = ~clock;

  dcct_top dut_u (
    .clock        (clock),
    .rst_n        (rst_n),
    .ce           (1'b1),
    .wb_cyc_i     (wbCyc),
    .wb_stb_i     (wbStb),
    .wb_we_i      (wbWe),
    .wb_adr_i     (wbAdr),
    .wb_sel_i     (wbSel),
    .wb_dat_i     (wbDatI),
    .wb_dat_o     (wbDatO),
    .wb_ack_o     (wbAck),
    .inByteValid  (inByteValid),
    .inByteData   (inByteData),
    .inByteReady  (inByteReady),
    .cellStart    (cellStart),
    .patternMatch (patternMatch),
    .outByteValid (outByteValid),
    .outByteData  (outByteData),
    .outByteReady (outByteReady),
    .cellDone     (cellDone)
  );

  dcct_partner far_u (
    .clock        (clock),
    .rst_n        (rst_n),
    .srcOn        (srcOn),
    .allow        (allow),
    .inByteValid  (inByteValid),
    .inByteData   (inByteData),
    .inByteReady  (inByteReady),
    .outByteValid (outByteValid),
    .outByteReady (outByteReady)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [4:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbSel  <= s;
    wbDatI <= d;
    do @(posedge clock); while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, s, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 4'hf, 32'h0, q);
    check(q, exp);
  endtask

  // Pulse the start event (0) or the pattern match (1) for one cycle
  task automatic pulse(input int which);
    @(posedge clock);
    if (which == 0)
      cellStart <= 1'b1;
    else
      patternMatch <= 1'b1;
    @(posedge clock);
    cellStart    <= 1'b0;
    patternMatch <= 1'b0;
  endtask

  // Let n more bytes out and wait for them, bounded
  task automatic move(input int n);
    int k;
    int goal;
    goal  = moved + n;
    allow <= goal;
    k     = 0;
    while (moved < goal && k < 70000)
    begin
      @(posedge clock);
      k++;
    end
    repeat (2) @(posedge clock);
  endtask

  task automatic finalReport();
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Byte order monitor and cell-end counter
  always @(posedge clock)
    if (rst_n && outByteValid === 1'b1 && outByteReady === 1'b1)
    begin
      check({24'h0, outByteData}, {24'h0, expByte});
      expByte <= expByte + 8'h01;
      moved++;
    end

  always @(posedge clock)
    if (rst_n && cellDone === 1'b1)
      dones++;

  // Watchdog: the full-size cell takes about 65535 cycles and its move call waits 70000, the rest little
  initial
  begin
    #(20 * 90000);
    errTotal++;
    finalReport();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd(dcct_pkg::OFS_SIZE, 32'h0);
    rd(dcct_pkg::OFS_PTR, 32'h0);
    wr(dcct_pkg::OFS_SIZE, 32'hffffffff, 4'hf);
    rd(dcct_pkg::OFS_SIZE, 32'h0000ffff);
    wr(dcct_pkg::OFS_SIZE, 32'h00001234, 4'hf);
    wr(dcct_pkg::OFS_SIZE, 32'h000000ab, 4'h1);
    rd(dcct_pkg::OFS_SIZE, 32'h000012ab);
    wr(dcct_pkg::OFS_PTR, 32'hffffffff, 4'hf);
    rd(dcct_pkg::OFS_PTR, 32'h0);
    rd(5'h10, 32'h0);
    // Fill the buffer until it refuses, sink stalled
    wr(dcct_pkg::OFS_SIZE, 32'h3, 4'hf);
    srcOn <= 1'b1;
    repeat (40) @(posedge clock);
    rd(dcct_pkg::OFS_STAT, 32'h00002000);
    check({31'h0, inByteReady}, 32'h0);
    check({31'h0, outByteValid}, 32'h0);
    pulse(0);
    move(1);
    rd(dcct_pkg::OFS_PTR, 32'h1);
    move(2);
    check(dones, 1);
    rd(dcct_pkg::OFS_PTR, 32'h0);
    // Pattern mode clears the pointer mid-cell
    wr(dcct_pkg::OFS_CTRL, 32'h1, 4'hf);
    rd(dcct_pkg::OFS_CTRL, 32'h1);
    wr(dcct_pkg::OFS_SIZE, 32'h5, 4'hf);
    pulse(0);
    move(2);
    rd(dcct_pkg::OFS_PTR, 32'h2);
    pulse(1);
    rd(dcct_pkg::OFS_PTR, 32'h0);
    // Without pattern mode a match is ignored
    wr(dcct_pkg::OFS_CTRL, 32'h0, 4'hf);
    pulse(0);
    move(2);
    pulse(1);
    rd(dcct_pkg::OFS_PTR, 32'h2);
    move(3);
    check(dones, 2);
    // All ones moves 65535 bytes in one cell
    wr(dcct_pkg::OFS_SIZE, 32'hffff, 4'hf);
    pulse(0);
    move(70000);
    check(moved, 65545);
    check(dones, 3);
    // Drain the full buffer to empty with the source off
    srcOn <= 1'b0;
    wr(dcct_pkg::OFS_SIZE, 32'h20, 4'hf);
    pulse(0);
    move(32);
    check(dones, 4);
    rd(dcct_pkg::OFS_STAT, 32'h0);
    finalReport();
  end
endmodule
